// ==== src/i2c_ctl_pkg.sv ====
// Purpose: constants for the two-wire bus control block
// Assumes: 32-bit AXI4-Lite register bus, byte address = index * 4
// Notes: indices that are not multiples of four are word indices
//
// Notes on behaviour
// - track bus free or busy from start and stop conditions on the lines.
// - initial busy state comes from initial-state select, flag bit 1.
// - flag bits: 0 reservation disable, 1 initial select, 6 busy, 7 start fail.
// - control bits 7..0: wait cancel, enable, exit, stop irq, wait point, ack, start, stop.
// - control register at FFA6H, resets to 00H, takes byte writes.
// - enable low halts serial operation and holds status register in reset.
// - writing exit abandons transfer, enters standby, releases both lines.
// - exit bit clears itself after the exit action is done.
// - exit clears start, stop triggers and master, ext, match, tx, ack, start flags.
// - standby lasts until stop seen, or match or extension after a start.
// - writing wait cancel ends the wait, releases clock, then self-clears.
// - cancel during ninth-clock wait while transmitting releases data, clears tx flag.
// - reservation disabled and bus busy: start request ignored, start fail set.
// - clock high, data low at enable is a start; software exits right after.
package i2c_ctl_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W       = 18;
  localparam logic [15:0] CTRL_IDX     = 16'hFFA6;
  localparam logic [15:0] FLAG_IDX     = 16'hFFA7;
  localparam logic [15:0] STAT_IDX     = 16'hFFA8;
  localparam logic [15:0] IRQ_STAT_IDX = 16'hFFA9;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hFFAA;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  FLAG_RST     = 8'h00;
  localparam logic [7:0]  STAT_RST     = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // control bit positions
  localparam int CB_WAIT_CANCEL = 7;
  localparam int CB_OP_EN       = 6;
  localparam int CB_EXIT        = 5;
  localparam int CB_STOP_IRQ    = 4;
  localparam int CB_WAIT_SEL    = 3;
  localparam int CB_ACK_EN      = 2;
  localparam int CB_START       = 1;
  localparam int CB_STOP        = 0;

  // flag bit positions
  localparam int FB_RSV_DIS  = 0;
  localparam int FB_INIT_SEL = 1;
  localparam int FB_BUSY     = 6;
  localparam int FB_FAIL     = 7;

  // status bit positions
  localparam int SB_MASTER = 7;
  localparam int SB_EXT    = 6;
  localparam int SB_ADDR   = 5;
  localparam int SB_TX     = 4;
  localparam int SB_ACKD   = 3;
  localparam int SB_STD    = 2;
  localparam int SB_SPD    = 1;
  localparam logic [7:0] STAT_EXIT_KEEP = 8'h03;

  // interrupt bit positions
  localparam int IRQ_W    = 4;
  localparam int IB_START = 0;
  localparam int IB_STOP  = 1;
  localparam int IB_FAIL  = 2;
  localparam int IB_WAIT  = 3;

  // start and stop generator
  typedef enum logic [1:0] {
    GEN_IDLE  = 2'b00,
    GEN_START = 2'b01,
    GEN_STOP  = 2'b10
  } gen_state_e;

endpackage : i2c_ctl_pkg

// ==== src/line_sync_detect.sv ====
// Purpose: synchronise clock and data lines, find start and stop
// Assumes: lines are asynchronous to the core clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module line_sync_detect
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_clk_en,
  // raw lines
  input  wire logic i_scl,
  input  wire logic i_sda,
  // clean lines and events
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_start,
  output logic      o_stop
);

  logic [1:0] scl_meta_reg;
  logic [1:0] sda_meta_reg;
  logic       sda_prev_reg;

  // ************************************************************
  // two-stage synchronisers, idle lines read high
  // ************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
    end
    else if (i_clk_en)
    begin
      scl_meta_reg <= {scl_meta_reg[0], i_scl};
      sda_meta_reg <= {sda_meta_reg[0], i_sda};
    end
  end

  // data edge while clock high marks start or stop
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      sda_prev_reg <= 1'b1;
      o_scl        <= 1'b1;
      o_sda        <= 1'b1;
      o_start      <= 1'b0;
      o_stop       <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sda_prev_reg <= sda_meta_reg[1];
      o_scl        <= scl_meta_reg[1];
      o_sda        <= sda_meta_reg[1];
      o_start      <= scl_meta_reg[1] & sda_prev_reg & !sda_meta_reg[1];
      o_stop       <= scl_meta_reg[1] & !sda_prev_reg & sda_meta_reg[1];
    end
  end

endmodule : line_sync_detect
`default_nettype wire

// ==== src/i2c_control_enable_release.sv ====
// Purpose: bus control, enable, exit and wait release of a two-wire port
// Assumes: shift engine on the same clock drives wait and status pulses
// Notes: lines are open drain; oe_n low means the pin is pulled low
`timescale 1ns/1ps
`default_nettype none
module i2c_control_enable_release
  import i2c_ctl_pkg::*;
(
  // clock, reset, enable
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_clk_en,
  // axi4-lite write
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  // axi4-lite read
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  // bus lines
  input  wire logic              i_scl,
  output logic                   o_scl,
  output logic                   o_scl_oe_n,
  input  wire logic              i_sda,
  output logic                   o_sda,
  output logic                   o_sda_oe_n,
  // shift engine side
  input  wire logic              i_wait_req,
  input  wire logic              i_wait_ninth,
  input  wire logic              i_sda_low,
  input  wire logic [7:0]        i_stat_set,
  input  wire logic [7:0]        i_stat_clr,
  output logic                   o_op_enable,
  output logic                   o_standby,
  output logic                   o_waiting,
  output logic [7:0]             o_ctrl,
  // interrupt
  output logic                   o_irq
);

  logic             scl_s;
  logic             sda_s;
  logic             start_pulse;
  logic             stop_pulse;
  logic [7:0]       ctrl_reg;
  logic [7:0]       stat_reg;
  logic [7:0]       stat_next;
  logic             rsv_dis_reg;
  logic             init_sel_reg;
  logic             busy_reg;
  logic             fail_reg;
  logic             op_en_d_reg;
  logic             standby_reg;
  logic             wait_reg;
  logic             wait9_reg;
  logic             tx_rel_reg;
  gen_state_e       gen_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_next;
  logic [IRQ_W-1:0] irq_ev;
  logic [15:0]      aw_idx_reg;
  logic [31:0]      wdata_reg;
  logic             wlane_reg;
  logic             wr_fire;
  logic             wr_ctrl;
  logic [15:0]      rd_idx;
  logic             op_en;
  logic             exit_go;
  logic             start_hit;
  logic             stop_hit;
  logic             start_req;
  logic             start_refuse;
  logic             start_go;
  logic             stop_go;
  logic             start_done;
  logic             stop_done;
  logic             cancel_go;
  logic             tx_cancel;
  logic             sda_drive;

  // ************************************************************
  // line synchroniser and condition detector
  // ************************************************************
  line_sync_detect u_lines
  (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_clk_en   (i_clk_en),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_scl      (scl_s),
    .o_sda      (sda_s),
    .o_start    (start_pulse),
    .o_stop     (stop_pulse)
  );

  // ************************************************************
  // event decode
  // ************************************************************
  assign op_en        = ctrl_reg[CB_OP_EN];
  assign exit_go      = ctrl_reg[CB_EXIT];
  assign cancel_go    = ctrl_reg[CB_WAIT_CANCEL] & !exit_go;
  assign tx_cancel    = cancel_go & wait_reg & wait9_reg & stat_reg[SB_TX];
  // a low data line with the clock high at the moment of enabling counts as a start
  assign start_hit    = op_en & !exit_go &
                        (start_pulse | (!op_en_d_reg & scl_s & !sda_s));
  assign stop_hit     = op_en & stop_pulse;
  assign start_req    = op_en & !exit_go & !standby_reg & ctrl_reg[CB_START] &
                        (gen_reg == GEN_IDLE);
  assign start_refuse = start_req & rsv_dis_reg & busy_reg;
  assign start_go     = start_req & !busy_reg;
  assign stop_go      = op_en & !exit_go & ctrl_reg[CB_STOP] & !ctrl_reg[CB_START] &
                        (gen_reg == GEN_IDLE) & stat_reg[SB_MASTER];
  assign start_done   = (gen_reg == GEN_START) & start_pulse;
  assign stop_done    = (gen_reg == GEN_STOP) & stop_pulse;

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  assign wr_fire = !o_awready & !o_wready & !o_bvalid;
  assign wr_ctrl = wr_fire & wlane_reg & (aw_idx_reg == CTRL_IDX);
  assign rd_idx  = i_araddr[ADDR_W-1:2];

  // write address and data capture, response
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      o_awready  <= 1'b1;
      o_wready   <= 1'b1;
      o_bvalid   <= 1'b0;
      o_bresp    <= RESP_OKAY;
      aw_idx_reg <= 16'h0000;
      wdata_reg  <= 32'h0000_0000;
      wlane_reg  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (i_awvalid && o_awready)
      begin
        o_awready  <= 1'b0;
        aw_idx_reg <= i_awaddr[ADDR_W-1:2];
      end
      if (i_wvalid && o_wready)
      begin
        o_wready  <= 1'b0;
        wdata_reg <= i_wdata;
        wlane_reg <= i_wstrb[0];
      end
      if (wr_fire)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= (aw_idx_reg inside {CTRL_IDX, FLAG_IDX, STAT_IDX, IRQ_STAT_IDX,
                     IRQ_MASK_IDX}) ? RESP_OKAY : RESP_SLVERR;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // read channel, data captured with the address
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rresp   <= RESP_OKAY;
        unique case (rd_idx)
          CTRL_IDX:     o_rdata <= {24'h000000, ctrl_reg};
          FLAG_IDX:     o_rdata <= {24'h000000, fail_reg, busy_reg, 4'h0,
                                    init_sel_reg, rsv_dis_reg};
          STAT_IDX:     o_rdata <= {24'h000000, stat_reg};
          IRQ_STAT_IDX: o_rdata <= {28'h0000000, irq_stat_reg};
          IRQ_MASK_IDX: o_rdata <= {28'h0000000, irq_mask_reg};
          default:
          begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (o_rvalid && i_rready)
      begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      ctrl_reg <= CTRL_RST;
    else if (i_clk_en)
    begin
      if (wr_ctrl)
        ctrl_reg <= wdata_reg[7:0];
      else if (exit_go)
      begin
        ctrl_reg[CB_EXIT]  <= 1'b0;
        ctrl_reg[CB_START] <= 1'b0;
        ctrl_reg[CB_STOP]  <= 1'b0;
      end
      else
      begin
        if (ctrl_reg[CB_WAIT_CANCEL])
          ctrl_reg[CB_WAIT_CANCEL] <= 1'b0;
        if (start_refuse || start_done || !op_en)
          ctrl_reg[CB_START] <= 1'b0;
        if (stop_done || !op_en)
          ctrl_reg[CB_STOP] <= 1'b0;
      end
    end
  end

  a_exit_self_clr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && exit_go && !wr_ctrl) |=> !ctrl_reg[CB_EXIT])
    else $error("exit bit did not clear");
  a_exit_clr_trig: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && exit_go && !wr_ctrl) |=>
    (ctrl_reg[CB_START] == 1'b0) && !ctrl_reg[CB_STOP] && ((stat_reg & ~STAT_EXIT_KEEP) == 8'h00))
    else $error("exit left triggers or flags set");

  // ************************************************************
  // flag register and bus state
  // ************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      rsv_dis_reg  <= FLAG_RST[FB_RSV_DIS];
      init_sel_reg <= FLAG_RST[FB_INIT_SEL];
      busy_reg     <= FLAG_RST[FB_BUSY];
      fail_reg     <= FLAG_RST[FB_FAIL];
      op_en_d_reg  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      op_en_d_reg <= op_en;
      if (wr_fire && wlane_reg && (aw_idx_reg == FLAG_IDX))
      begin
        rsv_dis_reg  <= wdata_reg[FB_RSV_DIS];
        init_sel_reg <= wdata_reg[FB_INIT_SEL];
      end
      if (!op_en)
        busy_reg <= !init_sel_reg;
      else if (start_hit)
        busy_reg <= 1'b1;
      else if (stop_hit)
        busy_reg <= 1'b0;
      if (!op_en)
        fail_reg <= 1'b0;
      else if (start_refuse)
        fail_reg <= 1'b1;
      else if (start_go)
        fail_reg <= 1'b0;
    end
  end

  a_busy_init: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && !op_en) |=> (busy_reg == !$past(init_sel_reg)))
    else $error("busy does not follow initial select");
  a_busy_track: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && op_en && start_pulse && !exit_go) |=> busy_reg)
    else $error("start did not mark bus busy");
  a_start_refuse: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && start_req && rsv_dis_reg && busy_reg && !wr_ctrl) |=>
    fail_reg && !ctrl_reg[CB_START] && (gen_reg == GEN_IDLE))
    else $error("start on busy bus not refused");

  // ************************************************************
  // status register, set wins over clear
  // ************************************************************
  always_comb
  begin
    stat_next = (stat_reg & ~i_stat_clr) | (standby_reg ?
                (i_stat_set & ((8'h01 << SB_ADDR) | (8'h01 << SB_EXT))) : i_stat_set);
    if (stop_hit)
      stat_next[SB_MASTER] = 1'b0;
    if (start_done)
      stat_next[SB_MASTER] = 1'b1;
    if (start_hit)
      stat_next[SB_STD] = 1'b1;
    if (stop_hit)
      stat_next[SB_SPD] = 1'b1;
    if (tx_cancel)
      stat_next[SB_TX] = 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      stat_reg <= STAT_RST;
    else if (i_clk_en)
    begin
      if (!op_en)
        stat_reg <= STAT_RST;
      else if (exit_go)
        stat_reg <= stat_reg & STAT_EXIT_KEEP;
      else
        stat_reg <= stat_next;
    end
  end

  a_off_stat_rst: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && !op_en) |=> (stat_reg == STAT_RST) && o_scl_oe_n && o_sda_oe_n)
    else $error("status or lines active while disabled");

  // ************************************************************
  // standby and wait
  // ************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      standby_reg <= 1'b0;
    else if (i_clk_en)
    begin
      if (!op_en)
        standby_reg <= 1'b0;
      else if (exit_go)
        standby_reg <= 1'b1;
      else if (stop_hit || (stat_reg[SB_STD] && (i_stat_set[SB_ADDR] || i_stat_set[SB_EXT])))
        standby_reg <= 1'b0;
    end
  end

  a_standby_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && op_en && standby_reg && !stop_pulse &&
     !(stat_reg[SB_STD] && (i_stat_set[SB_ADDR] || i_stat_set[SB_EXT]))) |=> standby_reg)
    else $error("standby left without entry condition");

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      wait_reg   <= 1'b0;
      wait9_reg  <= 1'b0;
      tx_rel_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (!op_en || exit_go || cancel_go)
        wait_reg <= 1'b0;
      else if (i_wait_req && !standby_reg)
      begin
        wait_reg   <= 1'b1;
        wait9_reg  <= i_wait_ninth;
        tx_rel_reg <= 1'b0;
      end
      if (tx_cancel)
        tx_rel_reg <= 1'b1;
    end
  end

  a_wait_cancel: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && cancel_go && !wr_ctrl) |=> !wait_reg && !ctrl_reg[CB_WAIT_CANCEL]
    ##1 (!i_clk_en || o_scl_oe_n || gen_reg != GEN_IDLE))
    else $error("wait cancel did not release clock");
  a_ninth_tx_rel: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && tx_cancel && !wr_ctrl) |=> !stat_reg[SB_TX] && tx_rel_reg)
    else $error("ninth-clock cancel kept transmit state");

  // ************************************************************
  // start and stop generator
  // ************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      gen_reg <= GEN_IDLE;
    else if (i_clk_en)
    begin
      if (!op_en || exit_go)
        gen_reg <= GEN_IDLE;
      else
      begin
        unique case (gen_reg)
          GEN_IDLE:
            if (start_go)
              gen_reg <= GEN_START;
            else if (stop_go)
              gen_reg <= GEN_STOP;
          GEN_START:
            if (start_pulse)
              gen_reg <= GEN_IDLE;
          GEN_STOP:
            if (stop_pulse)
              gen_reg <= GEN_IDLE;
          default:
            gen_reg <= GEN_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // open-drain line drive
  // ************************************************************
  assign sda_drive = (gen_reg == GEN_START) || ((gen_reg == GEN_STOP) && !scl_s) ||
                     (i_sda_low && !standby_reg && !tx_rel_reg && (gen_reg == GEN_IDLE));

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      o_scl      <= 1'b0;
      o_sda      <= 1'b0;
      o_scl_oe_n <= 1'b1;
      o_sda_oe_n <= 1'b1;
    end
    else if (i_clk_en)
    begin
      if (!op_en || exit_go)
      begin
        o_scl_oe_n <= 1'b1;
        o_sda_oe_n <= 1'b1;
      end
      else
      begin
        o_scl_oe_n <= !(wait_reg && !cancel_go && (gen_reg == GEN_IDLE));
        o_sda_oe_n <= !sda_drive;
      end
    end
  end

  a_exit_release: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && exit_go && !wr_ctrl) |=> o_scl_oe_n && o_sda_oe_n && standby_reg)
    else $error("exit did not release the lines");

  // ************************************************************
  // engine outputs and interrupt
  // ************************************************************
  assign irq_ev = {i_clk_en && i_wait_req && op_en && !standby_reg, start_refuse,
                   stop_hit && ctrl_reg[CB_STOP_IRQ], start_hit};
  always_comb
  begin
    irq_next = irq_stat_reg;
    if (wr_fire && wlane_reg && (aw_idx_reg == IRQ_STAT_IDX))
      irq_next = irq_next & ~wdata_reg[IRQ_W-1:0];
    irq_next = irq_next | irq_ev;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      o_irq        <= 1'b0;
      o_op_enable  <= 1'b0;
      o_standby    <= 1'b0;
      o_waiting    <= 1'b0;
      o_ctrl       <= CTRL_RST;
    end
    else if (i_clk_en)
    begin
      irq_stat_reg <= irq_next;
      if (wr_fire && wlane_reg && (aw_idx_reg == IRQ_MASK_IDX))
        irq_mask_reg <= wdata_reg[IRQ_W-1:0];
      o_irq       <= |(irq_next & irq_mask_reg);
      o_op_enable <= op_en;
      o_standby   <= standby_reg;
      o_waiting   <= wait_reg;
      o_ctrl      <= ctrl_reg;
    end
  end

endmodule : i2c_control_enable_release
`default_nettype wire

// ==== dv/bus_partner.sv ====
// Purpose: other party on the two-wire bus
// Assumes: pull-ups on both lines
// Notes: lines stand still outside frames
`timescale 1ns/1ps
`default_nettype none
module bus_partner
(
  // device enables
  input  wire logic i_scl_oe_n,
  input  wire logic i_sda_oe_n,
  // wired lines
  output logic      o_scl,
  output logic      o_sda
);
  logic scl_rel = 1'b1;
  logic sda_rel = 1'b1;
  // wired-and with pull-up
  assign o_scl = scl_rel & i_scl_oe_n;
  assign o_sda = sda_rel & i_sda_oe_n;
  // start: data falls while clock high
  task automatic frame_start;
    sda_rel = 1'b0;
    #80 scl_rel = 1'b0;
  endtask : frame_start
  // stop: data rises while clock high
  task automatic frame_stop;
    #80 scl_rel = 1'b1;
    #80 sda_rel = 1'b1;
  endtask : frame_stop
endmodule : bus_partner
`default_nettype wire

// ==== dv/i2c_control_enable_release_tb.sv ====
// Purpose: self-checking bench for the bus control block
// Assumes: partner model drives the far side of the lines
// Notes: register traffic over axi4-lite, seed fixed
`timescale 1ns/1ps
`default_nettype none
module i2c_control_enable_release_tb;
  import i2c_ctl_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic wq = 1'b0, w9 = 1'b0, sdl = 1'b0, awr, wr, bv, arr, rvl, scl, sda, scoe, sdoe, irq;
  logic opn, sby, wtg;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdv, rd;
  logic [7:0] ss = '0, cb;
  logic [1:0] br, rr;
  int err_total = 0, samples_checked = 0, cyc = 0;
  // free-running core clock
  always #10 clk = ~clk;
  bus_partner P (.i_scl_oe_n(scoe), .i_sda_oe_n(sdoe), .o_scl(scl), .o_sda(sda));
  i2c_control_enable_release DUT (.i_core_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr),
    .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(bry), .o_bresp(br),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rvl), .i_rready(rry),
    .o_rdata(rd), .o_rresp(rr), .i_scl(scl), .o_scl(), .o_scl_oe_n(scoe), .i_sda(sda),
    .o_sda(), .o_sda_oe_n(sdoe), .i_wait_req(wq), .i_wait_ninth(w9), .i_sda_low(sdl),
    .i_stat_set(ss), .i_stat_clr(8'h00), .o_op_enable(opn), .o_standby(sby),
    .o_waiting(wtg), .o_ctrl(), .o_irq(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(negedge clk);
  endtask : cy
  // one write; ready sampled mid-cycle, released after the taking edge
  task automatic wreg(input logic [15:0] ix, input logic [7:0] d, input logic [1:0] e);
    logic a, w, b;
    logic [1:0] rsp;
    b = 1'b0;
    @(posedge clk);
    {awv, wv, bry} <= 3'h7;
    awa <= {ix, 2'b00};
    wd <= {24'h0, d};
    while (!b)
    begin
      @(negedge clk);
      a = awv & awr;
      w = wv & wr;
      b = bv;
      rsp = br;
      @(posedge clk);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end
    bry <= 1'b0;
    chk({30'h0, rsp}, {30'h0, e});
  endtask : wreg
  task automatic rreg(input logic [15:0] ix, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
    logic a, r;
    logic [1:0] rsp;
    r = 1'b0;
    @(posedge clk);
    {arv, rry} <= 2'h3;
    ara <= {ix, 2'b00};
    while (!r)
    begin
      @(negedge clk);
      a = arv & arr;
      r = rvl;
      rdv = rd;
      rsp = rr;
      @(posedge clk);
      if (a) arv <= 1'b0;
    end
    rry <= 1'b0;
    chk(rdv & m, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : rreg
  // shift-engine wait pulse with status set
  task automatic pulse(input logic [7:0] s);
    @(posedge clk);
    {wq, w9, sdl} <= 3'h7;
    ss <= s;
    @(posedge clk);
    wq <= 1'b0;
    ss <= 8'h00;
  endtask : pulse
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h1E94));
    cb = 8'h40 | 8'($urandom() & 32'h1C);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rreg(CTRL_IDX, 32'hFF, 32'h00, RESP_OKAY);
    rreg(FLAG_IDX, 32'hFF, 32'h40, RESP_OKAY);
    wreg(FLAG_IDX, 8'h02, RESP_OKAY);
    rreg(FLAG_IDX, 32'hFF, 32'h02, RESP_OKAY);
    wreg(CTRL_IDX, cb, RESP_OKAY);
    rreg(CTRL_IDX, 32'hFF, {24'h0, cb}, RESP_OKAY);
    $display("test reset and enable done");
    P.frame_start();
    cy(8);
    rreg(FLAG_IDX, 32'h40, 32'h40, RESP_OKAY);
    wreg(FLAG_IDX, 8'h03, RESP_OKAY);
    wreg(CTRL_IDX, cb | 8'h02, RESP_OKAY);
    rreg(FLAG_IDX, 32'hFF, 32'hC3, RESP_OKAY);
    rreg(CTRL_IDX, 32'hFF, {24'h0, cb}, RESP_OKAY);
    P.frame_stop();
    cy(8);
    rreg(FLAG_IDX, 32'h40, 32'h00, RESP_OKAY);
    $display("test busy tracking done");
    pulse(8'hFC);
    wreg(CTRL_IDX, cb | 8'h20, RESP_OKAY);
    cy(2);
    chk({29'h0, sby, scoe, sdoe}, 32'h7);
    rreg(CTRL_IDX, 32'hFF, {24'h0, cb}, RESP_OKAY);
    rreg(STAT_IDX, 32'hFC, 32'h00, RESP_OKAY);
    P.frame_start();
    P.frame_stop();
    cy(8);
    chk({31'h0, sby}, 32'h0);
    $display("test exit done");
    pulse(8'h10);
    cy(2);
    chk({30'h0, wtg, scoe}, 32'h2);
    wreg(CTRL_IDX, cb | 8'h80, RESP_OKAY);
    cy(2);
    chk({29'h0, wtg, scoe, sdoe}, 32'h3);
    rreg(STAT_IDX, 32'h10, 32'h00, RESP_OKAY);
    rreg(CTRL_IDX, 32'hFF, {24'h0, cb}, RESP_OKAY);
    $display("test wait cancel done");
    chk({31'h0, irq}, 32'h0);
    wreg(IRQ_MASK_IDX, 8'h0F, RESP_OKAY);
    cy(2);
    chk({31'h0, irq}, 32'h1);
    wreg(IRQ_STAT_IDX, 8'h0F, RESP_OKAY);
    cy(2);
    chk({31'h0, irq}, 32'h0);
    rreg(16'h0123, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wreg(16'h0123, 8'h55, RESP_SLVERR);
    wreg(CTRL_IDX, 8'h00, RESP_OKAY);
    rreg(STAT_IDX, 32'hFF, 32'h00, RESP_OKAY);
    chk({31'h0, opn}, 32'h0);
    $display("test irq and disable done");
    // data held low by the partner while clock is high, then enable
    P.sda_rel = 1'b0;
    cy(8);
    wreg(CTRL_IDX, 8'h40, RESP_OKAY);
    wreg(CTRL_IDX, 8'h60, RESP_OKAY);
    rreg(FLAG_IDX, 32'h40, 32'h40, RESP_OKAY);
    chk({31'h0, sby}, 32'h1);
    $display("test enable with data low done");
    tally_and_finish();
  end
endmodule : i2c_control_enable_release_tb
`default_nettype wire
